//--- core/pixel_unpack_pkg.sv
package pixel_unpack_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] RUN_CONTROL_OFS  = 8'h00;
    localparam logic [7:0] FORMAT_OFS       = 8'h04;
    localparam logic [7:0] RED_SELECT_OFS   = 8'h08;
    localparam logic [7:0] GREEN_SELECT_OFS = 8'h0C;
    localparam logic [7:0] BLUE_SELECT_OFS  = 8'h10;
    localparam logic [7:0] STATUS_OFS       = 8'h14;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int RUN_ENABLE_BIT   = 0;
    localparam int FMT_SWAP_BIT     = 31;
    localparam int FMT_COUNT_LSB    = 3;
    localparam int FMT_COUNT_MSB    = 4;
    localparam int SEL_LOW_LSB      = 0;
    localparam int SEL_LOW_MSB      = 4;
    localparam int SEL_SIZE_LSB     = 8;
    localparam int SEL_SIZE_MSB     = 11;
    localparam int SEL_FALLBACK_LSB = 16;
    localparam int SEL_FALLBACK_MSB = 23;

    // ------------------------------------------------------------
    // reset values and write masks
    // ------------------------------------------------------------
    localparam logic [31:0] RUN_CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] FORMAT_RESET      = 32'h0000_0000;
    localparam logic [31:0] SELECT_RESET      = 32'h0000_0000;
    localparam logic [31:0] RUN_CONTROL_MASK  = 32'h0000_0001;
    localparam logic [31:0] FORMAT_MASK       = 32'h8000_0018;
    localparam logic [31:0] SELECT_MASK       = 32'h00FF_0F1F;

    typedef enum logic [1:0] {
        GATHER_IDLE,
        GATHER_BYTES,
        GATHER_EMIT
    } gather_state_e;

endpackage

//--- core/pixel_skid_buffer.sv
module pixel_skid_buffer
    import pixel_unpack_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             flush_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);

    // ------------------------------------------------------------
    // two-entry buffer: full throughput, no word lost on stall
    // ------------------------------------------------------------
    logic [WIDTH-1:0] entry_reg [2];
    logic             rd_ptr_reg;
    logic             wr_ptr_reg;
    logic [1:0]       count_reg;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_reg != 2'h2);
    assign out_valid_o = (count_reg != 2'h0);
    assign out_data_o  = entry_reg[rd_ptr_reg];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            entry_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || flush_i) begin
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule

//--- core/color_component_extract.sv
module color_component_extract
    import pixel_unpack_pkg::*;
(
    input  wire logic [31:0] word_i,
    input  wire logic [31:0] select_i,
    input  wire logic        use_fallback_i,
    output logic      [7:0]  color_o
);

    // ------------------------------------------------------------
    // bit-field extraction with msb replication
    // ------------------------------------------------------------
    logic [4:0]  low_index;
    logic [3:0]  size;
    logic [7:0]  fallback;
    logic [31:0] shifted;
    logic [7:0]  field;
    logic [7:0]  repeated;

    assign low_index = select_i[SEL_LOW_MSB:SEL_LOW_LSB];
    assign size      = select_i[SEL_SIZE_MSB:SEL_SIZE_LSB];
    assign fallback  = select_i[SEL_FALLBACK_MSB:SEL_FALLBACK_LSB];
    assign shifted   = word_i >> low_index;

    always_comb begin
        field    = 8'h00;
        repeated = 8'h00;
        color_o  = fallback;
        if (!use_fallback_i && size != 4'h0) begin
            // left-justify, then or in copies shifted down by the width; one bit needs seven
            field    = shifted[7:0] << (4'd8 - size);
            repeated = field;
            for (int k = 1; k < 8; k++) begin
                repeated = repeated | (field >> (k * size));
            end
            color_o  = (size >= 4'h8) ? shifted[7:0] : repeated;
        end
        // sizes above eight are left to software to avoid
    end

endmodule

//--- core/pixel_unpack_color_extract.sv
// Function
// - controller runs only while run-enable bit zero of run control is set.
// - writing run control starts the controller on enable, stops it on clear.
// - per pixel, take byte-count-plus-one bytes and build a 32-bit word.
// - byte count field sits at format bits 4:3, value is bytes minus one.
// - format bit 31 selects big endian reordering before component extraction.
// - little endian puts first byte at bits 7:0, later bytes higher lanes.
// - big endian puts first byte at bits 31:24, later bytes lower lanes.
// - separate red, green and blue selectors pick bit count and position.
// - selector bits 4:0 give the lowest extracted bit index.
// - selector bits 11:8 give width; widths 1-7 repeat msbs to eight bits.
// - fallback colour bits 23:16 used on zero width, underrun or blanking.
// - software writes reserved bits as zero; reserved bits read back as zero.
module pixel_unpack_color_extract
    import pixel_unpack_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone classic slave
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // byte stream from the line buffer
    input  wire logic [7:0]  byte_data_i,
    input  wire logic        byte_valid_i,
    output logic             byte_ready_o,
    // pixel request from display timing
    input  wire logic        visible_i,
    input  wire logic        pixel_req_i,
    // run status, colour, pixel valid and underrun outputs
    output logic             running_o,
    output logic [7:0]       red_o,
    output logic [7:0]       green_o,
    output logic [7:0]       blue_o,
    output logic             pixel_valid_o,
    output logic             underrun_o
);

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [31:0] run_control_reg;
    logic [31:0] format_reg;
    logic [31:0] red_select_reg;
    logic [31:0] green_select_reg;
    logic [31:0] blue_select_reg;

    logic        underrun_seen_reg;

    logic        ack_reg;
    logic        err_reg;
    logic [31:0] rdata_reg;

    logic        bus_req;
    logic        bus_write;
    logic        addr_hit;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0]  sel,
                                                input logic [31:0] mask);
        logic [31:0] result;
        result = old_val;

        for (int lane = 0; lane < 4; lane++) begin
            if (sel[lane]) begin
                result[lane*8 +: 8] = new_val[lane*8 +: 8];
            end
        end
        return result & mask;
    endfunction

    // a fresh request only while no ack is outstanding: single-cycle answer
    assign bus_req   = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
    assign bus_write = bus_req && wb_we_i;
    assign addr_hit  = (wb_adr_i == RUN_CONTROL_OFS)
                    || (wb_adr_i == FORMAT_OFS)
                    || (wb_adr_i == RED_SELECT_OFS)
                    || (wb_adr_i == GREEN_SELECT_OFS)
                    || (wb_adr_i == BLUE_SELECT_OFS)
                    || (wb_adr_i == STATUS_OFS);

    // registered answer: one cycle of latency keeps decode off the ack path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req && addr_hit;
            err_reg <= bus_req && !addr_hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_control_reg  <= RUN_CONTROL_RESET;
            format_reg       <= FORMAT_RESET;
            red_select_reg   <= SELECT_RESET;
            green_select_reg <= SELECT_RESET;
            blue_select_reg  <= SELECT_RESET;
        end else if (bus_write) begin
            unique case (wb_adr_i)
                RUN_CONTROL_OFS: begin
                    run_control_reg <= merge_bytes(run_control_reg, wb_dat_i, wb_sel_i,
                                                   RUN_CONTROL_MASK);
                end

                FORMAT_OFS: begin
                    format_reg <= merge_bytes(format_reg, wb_dat_i, wb_sel_i,
                                              FORMAT_MASK);
                end

                RED_SELECT_OFS: begin
                    red_select_reg <= merge_bytes(red_select_reg, wb_dat_i, wb_sel_i,
                                                  SELECT_MASK);
                end

                GREEN_SELECT_OFS: begin
                    green_select_reg <= merge_bytes(green_select_reg, wb_dat_i, wb_sel_i,
                                                    SELECT_MASK);
                end

                BLUE_SELECT_OFS: begin
                    blue_select_reg <= merge_bytes(blue_select_reg, wb_dat_i, wb_sel_i,
                                                   SELECT_MASK);
                end

                default: begin
                end
            endcase
        end
    end

    // read data is captured as the request is taken and held until the next one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (bus_req) begin
            unique case (wb_adr_i)
                RUN_CONTROL_OFS: begin
                    rdata_reg <= run_control_reg;
                end
                FORMAT_OFS: begin
                    rdata_reg <= format_reg;
                end
                RED_SELECT_OFS: begin
                    rdata_reg <= red_select_reg;
                end
                GREEN_SELECT_OFS: begin
                    rdata_reg <= green_select_reg;
                end
                BLUE_SELECT_OFS: begin
                    rdata_reg <= blue_select_reg;
                end
                STATUS_OFS: begin
                    rdata_reg <= {30'h0000_0000, underrun_seen_reg, running_o};
                end
                default: begin
                    rdata_reg <= 32'h0000_0000;
                end
            endcase
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;
    assign wb_dat_o = rdata_reg;

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    logic       run_enable;
    logic [1:0] byte_count_m1;
    logic       swap_order;

    assign run_enable    = run_control_reg[RUN_ENABLE_BIT];
    assign byte_count_m1 = format_reg[FMT_COUNT_MSB:FMT_COUNT_LSB];
    assign swap_order    = format_reg[FMT_SWAP_BIT];

    assign running_o     = run_enable;

    // ------------------------------------------------------------
    // two-entry buffer on the incoming bytes
    // ------------------------------------------------------------
    logic [7:0] buf_data;
    logic       buf_valid;
    logic       buf_ready;

    // flushed while stopped so a restart never sees stale bytes
    pixel_skid_buffer #(
        .WIDTH (8)
    ) u_byte_buffer (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .flush_i     (!run_enable),
        .in_data_i   (byte_data_i),
        .in_valid_i  (byte_valid_i && run_enable),
        .in_ready_o  (byte_ready_o),
        .out_data_o  (buf_data),
        .out_valid_o (buf_valid),
        .out_ready_i (buf_ready)
    );

    // ------------------------------------------------------------
    // byte gathering
    // ------------------------------------------------------------
    gather_state_e state_reg;
    logic [1:0]    index_reg;
    logic [31:0]   gather_reg;

    logic          take_byte;
    logic          last_byte;

    // pre-gather the next pixel so a request is served from ready bytes
    assign buf_ready = run_enable && (state_reg == GATHER_BYTES);
    assign take_byte = buf_ready && buf_valid;
    assign last_byte = (index_reg == byte_count_m1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= GATHER_IDLE;
            index_reg <= 2'h0;
        end else if (!run_enable) begin
            state_reg <= GATHER_IDLE;
            index_reg <= 2'h0;
        end else begin
            unique case (state_reg)
                GATHER_IDLE: begin
                    state_reg <= GATHER_BYTES;
                    index_reg <= 2'h0;
                end

                GATHER_BYTES: begin
                    if (take_byte) begin
                        index_reg <= index_reg + 2'h1;
                        if (last_byte) begin
                            state_reg <= GATHER_EMIT;
                        end
                    end
                end

                GATHER_EMIT: begin
                    if (pixel_req_i && visible_i) begin
                        state_reg <= GATHER_BYTES;
                        index_reg <= 2'h0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gather_reg <= 32'h0000_0000;
        end else if (take_byte) begin
            // unfetched lanes keep old data: undefined by definition
            if (swap_order) begin
                gather_reg[(3 - index_reg)*8 +: 8] <= buf_data;
            end else begin
                gather_reg[index_reg*8 +: 8] <= buf_data;
            end
        end
    end

    // ------------------------------------------------------------
    // component extraction and output stage
    // ------------------------------------------------------------
    logic       word_ready;
    logic       starved;
    logic       use_fallback;
    logic [7:0] red_next;
    logic [7:0] green_next;
    logic [7:0] blue_next;

    assign word_ready   = (state_reg == GATHER_EMIT);
    assign starved      = pixel_req_i && visible_i && run_enable && !word_ready;
    assign use_fallback = !run_enable || !visible_i || !word_ready;

    // index plus width beyond the fetched bytes reads undefined lanes

    color_component_extract u_red (
        .word_i         (gather_reg),
        .select_i       (red_select_reg),
        .use_fallback_i (use_fallback),
        .color_o        (red_next)
    );

    color_component_extract u_green (
        .word_i         (gather_reg),
        .select_i       (green_select_reg),
        .use_fallback_i (use_fallback),
        .color_o        (green_next)
    );

    color_component_extract u_blue (
        .word_i         (gather_reg),
        .select_i       (blue_select_reg),
        .use_fallback_i (use_fallback),
        .color_o        (blue_next)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pixel_valid_o <= 1'b0;
            underrun_o    <= 1'b0;
        end else begin
            pixel_valid_o <= pixel_req_i;
            underrun_o    <= starved;
        end
    end

    // colours also refresh while stopped, so fallback edits show at once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            red_o   <= 8'h00;
            green_o <= 8'h00;
            blue_o  <= 8'h00;
        end else if (pixel_req_i || !run_enable) begin
            red_o   <= red_next;
            green_o <= green_next;
            blue_o  <= blue_next;
        end
    end

    // sticky underrun flag; a new underrun wins over a clearing write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            underrun_seen_reg <= 1'b0;
        end else if (starved) begin
            underrun_seen_reg <= 1'b1;
        end else if (bus_write && wb_adr_i == STATUS_OFS
                     && wb_sel_i[0] && wb_dat_i[1]) begin
            underrun_seen_reg <= 1'b0;
        end
    end

endmodule

//--- bench/pixel_panel_model.sv
// --------------------------------------------------------
// display panel: latches every valid pixel it is handed
// --------------------------------------------------------
// a real panel has no back-pressure, so neither does this one
module pixel_panel_model (
    input  wire logic        clk_i,
    input  wire logic        valid_i,
    input  wire logic        under_i,
    input  wire logic [23:0] rgb_i,
    output logic      [23:0] rgb_o,
    output logic             under_o,
    output int               count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rgb_o = 24'h000000;
        under_o = 1'h0;
        count_o = 0;
    end
    always @(posedge clk_i) begin
        if (valid_i === 1'h1) begin
            rgb_o <= rgb_i;
            under_o <= under_i;
            count_o <= count_o + 1;
        end
    end
endmodule

//--- bench/pixel_unpack_asserts.sv
module pixel_unpack_asserts
    import pixel_unpack_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        byte_ready_o,
    input wire logic        visible_i,
    input wire logic        pixel_req_i,
    input wire logic        running_o,
    input wire logic        pixel_valid_o,
    input wire logic        underrun_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    function automatic logic mapped(logic [7:0] a);
        return a <= STATUS_OFS && a[1:0] == 2'h0;
    endfunction
    function automatic logic [31:0] rd_mask(logic [7:0] a);
        case (a)
            RUN_CONTROL_OFS: return RUN_CONTROL_MASK;
            FORMAT_OFS:      return FORMAT_MASK;
            STATUS_OFS:      return 32'h0000_0003;
            default:         return SELECT_MASK;
        endcase
    endfunction
    sequence bus_req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence run_write_s;
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == RUN_CONTROL_OFS;
    endsequence
    a_answer_next:
        assert property (bus_req_s |=> wb_ack_o != wb_err_o)
        else $error("bus request not answered in next cycle");
    a_err_unmapped:
        assert property (bus_req_s |=> wb_err_o == !mapped($past(wb_adr_i)))
        else $error("error response does not match address");
    a_ack_pulse:
        assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_run_write:
        assert property (run_write_s |=> running_o == $past(wb_dat_i[0]))
        else $error("running does not follow written enable");
    a_run_read:
        assert property (wb_ack_o && !wb_we_i && wb_adr_i == RUN_CONTROL_OFS
                         |-> wb_dat_o[0] == running_o)
        else $error("enable read back differs from running");
    a_reserved_zero:
        assert property (wb_ack_o && !wb_we_i |-> (wb_dat_o & ~rd_mask(wb_adr_i)) == 32'h0)
        else $error("reserved bits read nonzero");
    a_pixel_lag:
        assert property (pixel_valid_o == $past(pixel_req_i))
        else $error("pixel valid not one cycle after request");
    a_underrun_cause:
        assert property (underrun_o |-> pixel_valid_o
                         && $past(pixel_req_i && visible_i && running_o))
        else $error("underrun without visible request while running");
    a_stopped_ready:
        assert property (!running_o && $past(!running_o) |-> byte_ready_o)
        else $error("buffer not ready while stopped");
endmodule
bind pixel_unpack_color_extract pixel_unpack_asserts pixel_unpack_asserts_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .byte_ready_o(byte_ready_o), .visible_i(visible_i), .pixel_req_i(pixel_req_i),
    .running_o(running_o), .pixel_valid_o(pixel_valid_o), .underrun_o(underrun_o)
);

//--- bench/pixel_unpack_color_extract_test.sv
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module pixel_unpack_color_extract_test
    import pixel_unpack_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'h0, rst_i = 1'h1, wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
    logic        byte_valid_i = 1'h0, visible_i = 1'h0, pixel_req_i = 1'h0;
    logic [7:0]  wb_adr_i = 8'h00, byte_data_i = 8'h00, red_o, green_o, blue_o;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [3:0]  wb_sel_i = 4'h0;
    logic        wb_ack_o, wb_err_o, byte_ready_o, running_o, pixel_valid_o, underrun_o, er, acc;
    logic [23:0] seen_rgb;
    logic        seen_under;
    int          seen_cnt, n_errors = 0, checks = 0, cycles = 0, n;
    pixel_unpack_color_extract pixel_unpack_color_extract_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .byte_data_i(byte_data_i), .byte_valid_i(byte_valid_i), .byte_ready_o(byte_ready_o),
        .visible_i(visible_i), .pixel_req_i(pixel_req_i), .running_o(running_o),
        .red_o(red_o), .green_o(green_o), .blue_o(blue_o),
        .pixel_valid_o(pixel_valid_o), .underrun_o(underrun_o));
    pixel_panel_model pixel_panel_model_i (
        .clk_i(clk_i), .valid_i(pixel_valid_o), .under_i(underrun_o),
        .rgb_i({red_o, green_o, blue_o}), .rgb_o(seen_rgb), .under_o(seen_under),
        .count_o(seen_cnt));
    always #5 clk_i = ~clk_i;
    // ------------------------------------------------------------
    // hang guard: the whole run needs well under a thousand cycles
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        cycles++;
        if (cycles >= 5000) begin
            n_errors++;
            wrap_up();
        end
    end
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1);
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'h0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic push(input logic [7:0] b);
        int k;
        k = 0;
        @(posedge clk_i);
        byte_valid_i <= 1'h1;
        byte_data_i <= b;
        do begin @(posedge clk_i); k++; end while (byte_ready_o !== 1'h1 && k < 4);
        acc = (byte_ready_o === 1'h1);
        byte_valid_i <= 1'h0;
    endtask
    // request one pixel, then give the panel time to latch it
    task automatic pix(input logic v, input logic [23:0] e, input logic u);
        @(posedge clk_i);
        pixel_req_i <= 1'h1;
        visible_i <= v;
        @(posedge clk_i);
        pixel_req_i <= 1'h0;
        visible_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        `CHK({seen_under, seen_rgb}, {u, e})
    endtask
    function automatic logic [31:0] sel(logic [7:0] fb, logic [3:0] sz, logic [4:0] off);
        return {8'h00, fb, 4'h0, sz, 3'h0, off};
    endfunction
    // stopping first flushes leftovers of the previous case
    task automatic cfg(input logic [31:0] f, r, g, b);
        wb(1'h1, RUN_CONTROL_OFS, 32'h0);
        wb(1'h1, FORMAT_OFS, f);
        wb(1'h1, RED_SELECT_OFS, r);
        wb(1'h1, GREEN_SELECT_OFS, g);
        wb(1'h1, BLUE_SELECT_OFS, b);
        wb(1'h1, RUN_CONTROL_OFS, 32'h1);
    endtask
    task automatic run_px(input logic [31:0] f, r, g, b, by, input int nb, input logic [23:0] e);
        cfg(f, r, g, b);
        for (int i = 0; i < nb; i++) push(by[8*i +: 8]);
        repeat (6) @(posedge clk_i);
        pix(1'h1, e, 1'h0);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        for (int a = 0; a < 20; a += 4) rdchk(a[7:0], 32'h0);
        wb(1'h0, 8'h18, 32'h0);
        `CHK(er, 1'h1)
        wb(1'h1, FORMAT_OFS, 32'hFFFF_FFFF);
        rdchk(FORMAT_OFS, 32'h8000_0018);
        wb(1'h1, GREEN_SELECT_OFS, 32'hFFFF_FFFF);
        rdchk(GREEN_SELECT_OFS, 32'h00FF_0F1F);
        $display("test registers done");
        run_px(32'h18, sel(0, 8, 0), sel(0, 8, 8), sel(0, 7, 24), 32'h44332211, 4,
               24'h112289);
        run_px(32'h8000_0018, sel(0, 7, 25), sel(0, 4, 0), sel(8'h5A, 0, 0), 32'h44332211, 4,
               24'h10445A);
        run_px(32'h08, sel(0, 5, 10), sel(0, 6, 5), sel(0, 5, 0), 32'h3CA5, 2,
               24'h7B9629);
        run_px(32'h00, sel(0, 1, 6), sel(0, 3, 4), sel(0, 7, 0), 32'hC3, 1, 24'hFF9287);
        run_px(32'h10, sel(0, 7, 16), sel(0, 2, 14), sel(0, 8, 0), 32'hC0FFEE, 3,
               24'h81FFEE);
        $display("test unpack done");
        cfg(32'h0, sel(8'h12, 8, 0), sel(8'h34, 8, 0), sel(8'h56, 8, 0));
        push(8'h77);
        repeat (6) @(posedge clk_i);
        pix(1'h0, 24'h123456, 1'h0);
        pix(1'h1, 24'h777777, 1'h0);
        pix(1'h1, 24'h123456, 1'h1);
        rdchk(STATUS_OFS, 32'h3);
        wb(1'h1, STATUS_OFS, 32'h2);
        rdchk(STATUS_OFS, 32'h1);
        wb(1'h1, RUN_CONTROL_OFS, 32'h0);
        `CHK(running_o, 1'h0)
        push(8'hEE);
        pix(1'h1, 24'h123456, 1'h0);
        wb(1'h1, RUN_CONTROL_OFS, 32'h1);
        rdchk(RUN_CONTROL_OFS, 32'h1);
        push(8'h5C);
        repeat (6) @(posedge clk_i);
        pix(1'h1, 24'h5C5C5C, 1'h0);
        $display("test fallback done");
        cfg(32'h0, sel(0, 8, 0), sel(0, 8, 0), sel(0, 8, 0));
        n = 0;
        acc = 1'h1;
        while (acc && n < 8) begin
            push(8'h30 + n[7:0]);
            if (acc) n++;
        end
        `CHK(acc, 1'h0)
        for (int j = 0; j < n; j++) pix(1'h1, {3{8'h30 + j[7:0]}}, 1'h0);
        pix(1'h1, 24'h000000, 1'h1);
        `CHK(seen_cnt, 14)
        $display("test buffer done");
        wrap_up();
    end
endmodule
